// ===== rtl/serial_segment_exchange_regs.svh
// Purpose: Attribute numbers, field positions and reset values of the segment exchange.
// Assumes: Attributes are addressed by their number on the attribute access port.
// Notes: Included by the design.
//
// Contract
// (RULE1) Each receive segment reports its valid byte count, zero to seven.
// (RULE2) Receive tag advances 0,1,2,3,0 with every new input segment.
// (RULE3) Transmit acknowledge echoes the last output tag once its bytes are taken.
// (RULE4) Status bit is 1 while exchange is error free, 0 when disturbed.
// (RULE5) On disturbance with diagnostics released, diagnostic bits show the cause.
// (RULE6) Master restores status itself through the status clear request.
// (RULE7) Diagnostic byte is part of the input segment only in header mode 1.
// (RULE8) Diagnostic bits 0 to 2 reserved; bit 3 flags unsupported parameters.
// (RULE9) Diagnostic bit 4 flags an internal hardware failure.
// (RULE10) Diagnostic bit 5 flags terminal equipment ignoring flow control.
// (RULE11) Diagnostic bit 6 flags a character frame format mismatch.
// (RULE12) Diagnostic bit 7 flags receive overflow; bits 8 to 15 reserved.
// (RULE13) Received characters appear as byte array positions zero to seven.
// (RULE14) Reading the release variant of the receive array acknowledges it.
// (RULE15) Master states the valid byte count of each output segment.
// (RULE16) Master advances the transmit tag 0,1,2,3,0 per output segment.
// (RULE17) Status returns to 1 on request fall; request 0 ignores count/tag/ack changes.
// (RULE18) Mode 0 gives seven user bytes, mode 1 six user bytes plus diagnostics.
// (RULE19) Master acknowledges each receive segment by echoing its receive tag.
// (RULE20) Output segment is new only when its transmit tag differs from the last.
// (RULE21) A new receive segment is delivered only after the previous tag is acknowledged.
`ifndef SERIAL_SEGMENT_EXCHANGE_REGS_SVH
`define SERIAL_SEGMENT_EXCHANGE_REGS_SVH

`define ATTR_RX_COUNT 8'h70
`define ATTR_RX_TAG 8'h71
`define ATTR_TX_ECHO 8'h72
`define ATTR_LINK_HEALTH 8'h73
`define ATTR_FAULT_CAUSE 8'h74
`define ATTR_RX_ARRAY 8'h75
`define ATTR_RX_ARRAY_ACK 8'h76
`define ATTR_TX_COUNT 8'h77
`define ATTR_TX_TAG 8'h78
`define ATTR_RX_ACK 8'h79
`define ATTR_STATUS_CLEAR 8'h7a
`define ATTR_TX_ARRAY 8'h7c
`define ATTR_HEADER_MODE 8'h80
`define ATTR_DIAG_DISABLE 8'h82

`define DIAG_PARAM_BIT 3
`define DIAG_HW_BIT 4
`define DIAG_HANDSHAKE_BIT 5
`define DIAG_FRAME_BIT 6
`define DIAG_OVERFLOW_BIT 7

`define USER_BYTES_MODE0 3'h7
`define USER_BYTES_MODE1 3'h6

`define RST_LINK_HEALTH 1'b1
`define RST_HEADER_MODE 1'b0
`define RST_DIAG_DISABLE 1'b0
`define RST_STATUS_CLEAR 1'b0
`define RST_TAG 2'h0

`endif

// ===== rtl/serial_segment_pkg.sv
// Purpose: Types shared by the segment exchange.
// Assumes: Constants live in the _regs header.
// Notes: None.
package serial_segment_pkg;
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_type;
  typedef logic [7:0] byte_type;
  typedef logic [1:0] tag_type;
endpackage

// ===== rtl/serial_segment_exchange.sv
// Purpose: Segment level process data exchange between a fieldbus master and a serial link.
// Assumes: Attribute port and serial byte streams run on clock; one access per cycle.
// Notes: Get and set answer with one registered ack pulse; unknown attributes read zero.
`timescale 1ns/1ps
`include "serial_segment_exchange_regs.svh"

module serial_segment_exchange #(
  parameter int SEG_BYTES = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Attribute access from the master
  input wire logic [7:0] attr_num,
  input wire logic attr_get,
  input wire logic attr_set,
  input wire logic [63:0] attr_wdata,
  output logic [63:0] attr_rdata,
  output logic attr_ack,
  // Received characters from the serial controller
  input wire logic rx_char_valid,
  input wire serial_segment_pkg::byte_type rx_char,
  output logic rx_char_ready,
  // Characters to transmit to the serial controller
  output logic tx_char_valid,
  output serial_segment_pkg::byte_type tx_char,
  input wire logic tx_char_ready,
  // Fault events from the serial controller
  input wire logic param_fault,
  input wire logic hw_fault,
  input wire logic handshake_fault,
  input wire logic frame_fault
);
  import serial_segment_pkg::*;

  // Attribute state
  logic header_mode_q;
  logic diag_disable_q;
  logic clear_req_q;
  logic [2:0] tx_count_q;
  tag_type tx_tag_q;
  tag_type rx_ack_q;
  byte_type tx_array_q [SEG_BYTES];
  // Receive path
  byte_type stage_q [SEG_BYTES];
  logic [2:0] stage_cnt_q;
  byte_type seg_q [SEG_BYTES];
  logic [2:0] seg_cnt_q;
  tag_type rx_tag_q;
  // Transmit path
  tx_state_type tx_state_q;
  byte_type send_q [SEG_BYTES];
  logic [2:0] send_cnt_q;
  logic [2:0] send_idx_q;
  tag_type accepted_tag_q;
  tag_type tx_echo_q;
  // Health
  logic link_ok_q;
  byte_type diag_q;

  logic [2:0] user_cap;
  logic set_ok;
  logic clear_fall;
  logic publish;
  logic stage_full;
  logic fault_any;
  logic tx_new;
  logic [63:0] seg_flat;

  function automatic logic hit(input logic [7:0] num, input logic [7:0] attr);
    hit = (num == attr);
  endfunction

  assign user_cap = header_mode_q ? `USER_BYTES_MODE1 : `USER_BYTES_MODE0; // RULE18
  assign set_ok = attr_set & clear_req_q; // RULE17
  assign clear_fall = attr_set & hit(attr_num, `ATTR_STATUS_CLEAR) & clear_req_q
    & ~attr_wdata[0]; // RULE17
  assign stage_full = (stage_cnt_q >= user_cap);
  assign fault_any = param_fault | hw_fault | handshake_fault | frame_fault
    | (rx_char_valid & stage_full);
  assign publish = (rx_ack_q == rx_tag_q) && (stage_cnt_q != 3'h0); // RULE21
  assign tx_new = set_ok & hit(attr_num, `ATTR_TX_TAG)
    & (attr_wdata[1:0] != accepted_tag_q) & (tx_state_q == TX_IDLE); // RULE20
  assign rx_char_ready = 1'b1;
  assign tx_char_valid = (tx_state_q == TX_SEND);

  // Offered character register, loaded one step ahead of each take
  always_ff @(posedge clock)
  begin
    if (srst)
      tx_char <= 8'h00;
    else if (tx_new)
      tx_char <= tx_array_q[0];
    else if ((tx_state_q == TX_SEND) && tx_char_ready)
      tx_char <= send_q[send_idx_q + 3'h1];
  end

  genvar gi;
  generate
    for (gi = 0; gi < SEG_BYTES; gi++)
    begin : g_flat
      assign seg_flat[gi*8 +: 8] = seg_q[gi]; // RULE13
    end
  endgenerate

  // Configuration attributes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      header_mode_q <= `RST_HEADER_MODE;
      diag_disable_q <= `RST_DIAG_DISABLE;
      clear_req_q <= `RST_STATUS_CLEAR;
    end
    else if (attr_set)
    begin
      if (hit(attr_num, `ATTR_HEADER_MODE))
        header_mode_q <= attr_wdata[0];
      if (hit(attr_num, `ATTR_DIAG_DISABLE))
        diag_disable_q <= attr_wdata[0];
      if (hit(attr_num, `ATTR_STATUS_CLEAR))
        clear_req_q <= attr_wdata[0];
    end
  end

  // Output segment count and tag, taken only while the clear request is 1; the array is taken always
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tx_count_q <= 3'h0;
      tx_tag_q <= `RST_TAG;
    end
    else if (set_ok)
    begin
      if (hit(attr_num, `ATTR_TX_COUNT))
        tx_count_q <= (attr_wdata[7:0] > 8'h07) ? 3'h7 : attr_wdata[2:0]; // RULE15
      if (hit(attr_num, `ATTR_TX_TAG))
        tx_tag_q <= attr_wdata[1:0]; // RULE16
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < SEG_BYTES; i++)
        tx_array_q[i] <= 8'h00;
    end
    else if (attr_set && hit(attr_num, `ATTR_TX_ARRAY))
    begin
      for (int i = 0; i < SEG_BYTES; i++)
        tx_array_q[i] <= attr_wdata[i*8 +: 8];
    end
  end

  // Receive acknowledge: explicit echo or a read of the release array
  always_ff @(posedge clock)
  begin
    if (srst)
      rx_ack_q <= `RST_TAG;
    else if (attr_get && hit(attr_num, `ATTR_RX_ARRAY_ACK))
      rx_ack_q <= rx_tag_q; // RULE14
    else if (set_ok && hit(attr_num, `ATTR_RX_ACK))
      rx_ack_q <= attr_wdata[1:0]; // RULE19
  end

  // Staging of received characters
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage_cnt_q <= 3'h0;
      for (int i = 0; i < SEG_BYTES; i++)
        stage_q[i] <= 8'h00;
    end
    else
    begin
      if (publish)
        stage_cnt_q <= (rx_char_valid && (stage_cnt_q < user_cap)) ? 3'h1 : 3'h0;
      else if (rx_char_valid && !stage_full)
        stage_cnt_q <= stage_cnt_q + 3'h1;
      if (rx_char_valid && !stage_full)
      begin
        if (publish)
          stage_q[0] <= rx_char;
        else
          stage_q[stage_cnt_q] <= rx_char;
      end
    end
  end

  // Publishing of input segments
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      seg_cnt_q <= 3'h0;
      rx_tag_q <= `RST_TAG;
      for (int i = 0; i < SEG_BYTES; i++)
        seg_q[i] <= 8'h00;
    end
    else if (publish)
    begin
      seg_cnt_q <= stage_cnt_q; // RULE1
      rx_tag_q <= rx_tag_q + 2'h1; // RULE2
      for (int i = 0; i < SEG_BYTES; i++)
        seg_q[i] <= (i < int'(stage_cnt_q)) ? stage_q[i] : 8'h00;
    end
  end

  // Transmit sequencing
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tx_state_q <= TX_IDLE;
      send_cnt_q <= 3'h0;
      send_idx_q <= 3'h0;
      accepted_tag_q <= `RST_TAG;
      tx_echo_q <= `RST_TAG;
      for (int i = 0; i < SEG_BYTES; i++)
        send_q[i] <= 8'h00;
    end
    else
    begin
      unique case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_new)
          begin
            accepted_tag_q <= attr_wdata[1:0];
            send_cnt_q <= tx_count_q;
            send_idx_q <= 3'h0;
            for (int i = 0; i < SEG_BYTES; i++)
              send_q[i] <= tx_array_q[i];
            if (tx_count_q == 3'h0)
              tx_echo_q <= attr_wdata[1:0]; // RULE3
            else
              tx_state_q <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tx_char_ready)
          begin
            send_idx_q <= send_idx_q + 3'h1;
            if (send_idx_q + 3'h1 == send_cnt_q)
            begin
              tx_state_q <= TX_IDLE;
              tx_echo_q <= accepted_tag_q; // RULE3
            end
          end
        end
      endcase
    end
  end

  // Link health; a fault in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (srst)
      link_ok_q <= `RST_LINK_HEALTH;
    else if (fault_any)
      link_ok_q <= 1'b0; // RULE4
    else if (clear_fall)
      link_ok_q <= 1'b1; // RULE6 RULE17
  end

  // Diagnostic causes, latched while diagnostics are released
  always_ff @(posedge clock)
  begin
    if (srst)
      diag_q <= 8'h00;
    else if (!diag_disable_q && fault_any)
    begin
      diag_q[2:0] <= 3'h0; // RULE8
      diag_q[`DIAG_PARAM_BIT] <= diag_q[`DIAG_PARAM_BIT] | param_fault; // RULE5 RULE8
      diag_q[`DIAG_HW_BIT] <= diag_q[`DIAG_HW_BIT] | hw_fault; // RULE9
      diag_q[`DIAG_HANDSHAKE_BIT] <= diag_q[`DIAG_HANDSHAKE_BIT] | handshake_fault; // RULE10
      diag_q[`DIAG_FRAME_BIT] <= diag_q[`DIAG_FRAME_BIT] | frame_fault; // RULE11
      diag_q[`DIAG_OVERFLOW_BIT] <= diag_q[`DIAG_OVERFLOW_BIT]
        | (rx_char_valid & stage_full); // RULE12
    end
    else if (clear_fall || diag_disable_q)
      diag_q <= 8'h00;
  end

  // Attribute read data and acknowledge
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      attr_rdata <= 64'h0;
      attr_ack <= 1'b0;
    end
    else
    begin
      attr_ack <= attr_get | attr_set;
      attr_rdata <= 64'h0;
      if (attr_get)
      begin
        unique case (attr_num)
          `ATTR_RX_COUNT: attr_rdata <= {61'h0, seg_cnt_q}; // RULE1
          `ATTR_RX_TAG: attr_rdata <= {62'h0, rx_tag_q}; // RULE2
          `ATTR_TX_ECHO: attr_rdata <= {62'h0, tx_echo_q}; // RULE3
          `ATTR_LINK_HEALTH: attr_rdata <= {63'h0, link_ok_q}; // RULE4
          `ATTR_FAULT_CAUSE: attr_rdata <= {56'h0, header_mode_q ? diag_q : 8'h00}; // RULE7
          `ATTR_RX_ARRAY: attr_rdata <= seg_flat; // RULE13
          `ATTR_RX_ARRAY_ACK: attr_rdata <= seg_flat; // RULE14
          `ATTR_TX_COUNT: attr_rdata <= {61'h0, tx_count_q};
          `ATTR_TX_TAG: attr_rdata <= {62'h0, tx_tag_q};
          `ATTR_RX_ACK: attr_rdata <= {62'h0, rx_ack_q};
          `ATTR_STATUS_CLEAR: attr_rdata <= {63'h0, clear_req_q};
          `ATTR_HEADER_MODE: attr_rdata <= {63'h0, header_mode_q};
          `ATTR_DIAG_DISABLE: attr_rdata <= {63'h0, diag_disable_q};
          default: attr_rdata <= 64'h0;
        endcase
      end
    end
  end
endmodule // serial_segment_exchange

// ===== verification/segment_exchange_checker.sv
// Purpose: Port level assertions for the segment exchange.
// Assumes: Only the top module ports are visible.
// Notes: Bound to every instance of the design.
`timescale 1ns/1ps
module segment_exchange_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Attribute port
  input wire logic [7:0] attr_num,
  input wire logic attr_get,
  input wire logic attr_set,
  input wire logic [63:0] attr_rdata,
  input wire logic attr_ack,
  // Streams
  input wire logic rx_char_ready,
  input wire logic tx_char_valid,
  input wire serial_segment_pkg::byte_type tx_char,
  input wire logic tx_char_ready,
  // Fault events
  input wire logic param_fault,
  input wire logic hw_fault,
  input wire logic handshake_fault,
  input wire logic frame_fault
);
  import serial_segment_pkg::*;
  logic [7:0] got_q;
  logic flt;
  assign flt = param_fault | hw_fault | handshake_fault | frame_fault;
  // Attribute whose read answer stands in this cycle, zero when none
  always_ff @(posedge clock)
  begin
    got_q <= (attr_get && !srst) ? attr_num : 8'h00;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  ack_follows_req_a: assert property ((attr_get || attr_set) |=> attr_ack)
    else $error("no ack one cycle after access");
  idle_rdata_zero_a: assert property (!attr_ack |-> attr_rdata == 64'h0)
    else $error("read data not zero outside ack");
  count_range_a: assert property (got_q == 8'h70 |-> attr_rdata <= 64'h7)
    else $error("receive count above seven");
  rx_tag_range_a: assert property (got_q == 8'h71 |-> attr_rdata < 64'h4)
    else $error("receive tag out of range");
  echo_range_a: assert property (got_q == 8'h72 |-> attr_rdata < 64'h4)
    else $error("transmit echo out of range");
  health_width_a: assert property (got_q == 8'h73 |-> attr_rdata[63:1] == 63'h0)
    else $error("status wider than one bit");
  fault_drops_health_a: assert property (flt ##1 !attr_set ##1 (attr_get && attr_num == 8'h73)
    |=> attr_rdata[0] == 1'b0)
    else $error("status not cleared by fault");
  diag_reserved_a: assert property (got_q == 8'h74
    |-> attr_rdata[2:0] == 3'h0 && attr_rdata[63:8] == 56'h0)
    else $error("reserved diagnostic bits set");
  tx_start_a: assert property ($rose(tx_char_valid)
    |-> $past(attr_set) && $past(attr_num) == 8'h78)
    else $error("transmission without tag write");
  tx_hold_a: assert property (tx_char_valid && !tx_char_ready
    |=> tx_char_valid && $stable(tx_char))
    else $error("offered character changed before taken");
  rx_ready_a: assert property (rx_char_ready)
    else $error("receive ready dropped");
  tx_cov_c: cover property (tx_char_valid && tx_char_ready);
  fault_cov_c: cover property (flt);
  release_cov_c: cover property (got_q == 8'h76);
endmodule // segment_exchange_checker

bind serial_segment_exchange segment_exchange_checker prop_chk (.clock(clock), .srst(srst),
  .attr_num(attr_num), .attr_get(attr_get), .attr_set(attr_set), .attr_rdata(attr_rdata),
  .attr_ack(attr_ack), .rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
  .tx_char(tx_char), .tx_char_ready(tx_char_ready), .param_fault(param_fault),
  .hw_fault(hw_fault), .handshake_fault(handshake_fault), .frame_fault(frame_fault));

// ===== verification/serial_far_end.sv
// Purpose: Serial controller side of the segment exchange.
// Assumes: One character per push; the sink stalls one cycle in four.
// Notes: Idle receive data shows the inverse of the last character.
`timescale 1ns/1ps
module serial_far_end (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Streams
  output logic rx_char_valid,
  output serial_segment_pkg::byte_type rx_char,
  input wire logic tx_char_valid,
  input wire serial_segment_pkg::byte_type tx_char,
  output logic tx_char_ready
);
  import serial_segment_pkg::*;
  logic [1:0] stall_q = 2'h0;
  byte_type got[$];
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    tx_char_ready = 1'b1;
  end
  always @(posedge clock)
  begin
    stall_q <= srst ? 2'h0 : stall_q + 2'h1;
    tx_char_ready <= stall_q != 2'h3;
    if (tx_char_valid && tx_char_ready)
      got.push_back(tx_char);
  end
  task push(input byte_type b);
    @(posedge clock);
    rx_char_valid <= 1'b1;
    rx_char <= b;
    @(posedge clock);
    rx_char_valid <= 1'b0;
    rx_char <= ~b;
  endtask
endmodule // serial_far_end

// ===== verification/tb.sv
// Purpose: Self checking bench of the segment exchange.
// Assumes: The bench plays the master on the attribute port.
// Notes: Random data from a fixed seed.
`timescale 1ns/1ps
module tb;
  import serial_segment_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] attr_num = 8'h00;
  logic attr_get = 1'b0;
  logic attr_set = 1'b0;
  logic [63:0] attr_wdata = 64'h0;
  logic [63:0] attr_rdata;
  logic attr_ack;
  logic rx_char_valid;
  byte_type rx_char;
  logic rx_char_ready;
  logic tx_char_valid;
  byte_type tx_char;
  logic tx_char_ready;
  logic [3:0] flt = 4'h0;
  logic [63:0] rd;
  logic [63:0] exp;
  logic [63:0] old;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 43;
  int cycles = 0;
  int n;
  serial_segment_exchange uut (.clock(clock), .srst(srst), .attr_num(attr_num),
    .attr_get(attr_get), .attr_set(attr_set), .attr_wdata(attr_wdata),
    .attr_rdata(attr_rdata), .attr_ack(attr_ack), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_ready(tx_char_ready), .param_fault(flt[0]),
    .hw_fault(flt[1]), .handshake_fault(flt[2]), .frame_fault(flt[3]));
  serial_far_end far (.clock(clock), .srst(srst), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .tx_char_ready(tx_char_ready));
  function automatic logic [63:0] tag_of(input int k);
    return 64'(k % 4);
  endfunction
  task complete_run();
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One access; the answer is taken while its ack stands
  task acc(input logic s, input logic [7:0] a, input logic [63:0] w);
    @(posedge clock);
    attr_get <= !s;
    attr_set <= s;
    attr_num <= a;
    attr_wdata <= w;
    @(posedge clock);
    attr_get <= 1'b0;
    attr_set <= 1'b0;
    #1;
    rd = attr_rdata;
    cmp({63'h0, attr_ack}, 64'h1);
  endtask
  task chk(input logic [7:0] a, input logic [63:0] e);
    acc(1'b0, a, 64'h0);
    cmp(rd, e);
  endtask
  task fault(input logic [3:0] f);
    @(posedge clock);
    flt <= f;
    @(posedge clock);
    flt <= 4'h0;
  endtask
  task clr();
    acc(1'b1, 8'h7a, 64'h1);
    acc(1'b1, 8'h7a, 64'h0);
  endtask
  task feed(input int k);
    exp = 64'h0;
    for (int i = 0; i < k; i++)
    begin
      exp[8*i+:8] = 8'($random(seed));
      far.push(exp[8*i+:8]);
    end
    repeat (3) @(posedge clock);
  endtask
  task seg(input logic [63:0] t, input int k);
    chk(8'h71, t);
    chk(8'h70, 64'(k));
    chk(8'h75, exp);
  endtask
  task echo(input logic [63:0] t);
    rd = '1;
    for (int i = 0; i < 40 && rd !== t; i++)
      acc(1'b0, 8'h72, 64'h0);
    cmp(rd, t);
  endtask
  initial
  begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  initial
  begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    chk(8'h73, 64'h1);
    chk(8'h72, 64'h0);
    chk(8'h90, 64'h0);
    feed(1);
    seg(tag_of(1), 1);
    for (int k = 1; k < 6; k++)
    begin
      old = exp;
      n = k == 5 ? 7 : 1 + {$random(seed)} % 7;
      feed(n);
      chk(8'h71, tag_of(k));
      chk(8'h76, old);
      repeat (3) @(posedge clock);
      seg(tag_of(k + 1), n);
    end
    acc(1'b1, 8'h80, 64'h1);
    feed(7);
    exp[55:48] = 8'h00;
    chk(8'h73, 64'h0);
    chk(8'h74, 64'h80);
    acc(1'b0, 8'h76, 64'h0);
    repeat (3) @(posedge clock);
    seg(tag_of(7), 6);
    for (int i = 0; i < 4; i++)
    begin
      clr();
      chk(8'h73, 64'h1);
      fault(4'h1 << i);
      chk(8'h73, 64'h0);
      chk(8'h74, 64'h8 << i);
    end
    clr();
    acc(1'b1, 8'h82, 64'h1);
    fault(4'h2);
    chk(8'h74, 64'h0);
    acc(1'b1, 8'h82, 64'h0);
    acc(1'b1, 8'h80, 64'h0);
    fault(4'h8);
    chk(8'h74, 64'h0);
    acc(1'b1, 8'h7a, 64'h1);
    for (int k = 1; k < 6; k++)
    begin
      exp = {$random(seed), $random(seed)};
      n = k == 1 ? 0 : 1 + {$random(seed)} % 7;
      acc(1'b1, 8'h7c, exp);
      acc(1'b1, 8'h77, 64'(n));
      acc(1'b1, 8'h78, tag_of(k));
      echo(tag_of(k));
      cmp(64'(far.got.size()), 64'(n));
      for (int i = 0; i < n; i++)
        cmp(64'(far.got[i]), 64'(exp[8*i+:8]));
      far.got.delete();
    end
    acc(1'b1, 8'h78, tag_of(5));
    repeat (20) @(posedge clock);
    cmp(64'(far.got.size()), 64'h0);
    acc(1'b1, 8'h7a, 64'h0);
    acc(1'b1, 8'h78, tag_of(6));
    repeat (20) @(posedge clock);
    cmp(64'(far.got.size()), 64'h0);
    chk(8'h72, tag_of(5));
    feed(2);
    acc(1'b1, 8'h79, tag_of(7));
    repeat (3) @(posedge clock);
    chk(8'h71, tag_of(7));
    acc(1'b1, 8'h7a, 64'h1);
    acc(1'b1, 8'h79, tag_of(7));
    repeat (3) @(posedge clock);
    seg(tag_of(8), 2);
    complete_run();
  end
endmodule // tb
